// ### verilog/strap_regs_pkg.sv
// Purpose: constants for the strap and symbol status register group
// Assumes: AXI4-Lite, 32-bit data, byte address = 4 * register index
// Notes: registers are 16 bits wide, upper data bits read zero
package strap_regs_pkg;
    localparam logic [7:0] idle_cfg_index = 8'h53;
    localparam logic [7:0] skew_index = 8'h55;
    localparam logic [7:0] strap_first_index = 8'h6e;
    localparam logic [7:0] strap_second_index = 8'h6f;
    localparam logic [11:0] idle_cfg_reserved = 12'h205;
    localparam logic [3:0] idle_limit_reset = 4'h5;
    localparam int idle_limit_lsb = 0;
    localparam int lane_a_lsb = 0;
    localparam int lane_b_lsb = 4;
    localparam int mirror_bit = 15;
    localparam int downshift_bit = 14;
    localparam int clk_out_off_bit = 13;
    localparam int rgmii_off_bit = 12;
    localparam int crossover_off_bit = 10;
    localparam int forced_cross_bit = 9;
    localparam int half_duplex_bit = 8;
    localparam int autoneg_off_bit = 7;
    localparam int speed_lsb = 5;
    localparam int address_lsb = 0;
    localparam int quick_drop_bit = 10;
    localparam int tx_delay_lsb = 4;
    localparam int rx_delay_lsb = 0;
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;
endpackage : strap_regs_pkg

// ### verilog/phy_strap_and_symbol_status_regs.sv
// Purpose: strap status, lane skew and idle threshold registers on AXI4-Lite
// Assumes: straps are pins, caught on the second clock edge after reset release
// Notes: the idle detector's run length is counted here from an idle strobe
//        synchronisers keep running in reset so the capture sees settled pins
//        package-absent strap bits read zero whatever their pins show
//        one write and one read may be in flight at the same time
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
module phy_strap_and_symbol_status_regs #(
    parameter bit wide_package = 1'b1,
    parameter int addr_width = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [addr_width-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [addr_width-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] strap_first_pins,
    input wire logic [15:0] strap_second_pins,
    input wire logic [3:0] lane_a_delay_cycles,
    input wire logic [3:0] lane_b_delay_cycles,
    input wire logic idle_symbol_strobe,
    input wire logic symbol_strobe,
    output logic idle_mode
);
    typedef enum logic [2:0]
    {
        cap_sync0 = 3'b001,
        cap_sync1 = 3'b010,
        cap_done = 3'b100
    } cap_state_t;

    typedef struct packed {
        // strap capture
        cap_state_t cap;
        logic [15:0] first_meta;
        logic [15:0] first_sync;
        logic [15:0] second_meta;
        logic [15:0] second_sync;
        logic [15:0] strap_first;
        logic [15:0] strap_second;

        // idle detector and lane skew
        logic [3:0] idle_symbol_count_limit;
        logic [3:0] idle_run;
        logic idle_mode;
        logic [7:0] skew;

        // write channel
        logic aw_held;
        logic [7:0] aw_index;
        logic aw_ok;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;

        // read channel
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t st;
    state_t next_st;

    // word aligned and inside the 8-bit index space
    function automatic logic addr_ok(input logic [addr_width-1:0] a);
        addr_ok = (a[1:0] == 2'b00) && ((a >> 10) == '0);
    endfunction : addr_ok

    function automatic logic [7:0] addr_index(input logic [addr_width-1:0] a);
        addr_index = a[9:2];
    endfunction : addr_index

    function automatic logic index_mapped(input logic [7:0] i);
        index_mapped = (i == strap_regs_pkg::idle_cfg_index)
            || (i == strap_regs_pkg::skew_index)
            || (i == strap_regs_pkg::strap_first_index)
            || (i == strap_regs_pkg::strap_second_index);
    endfunction : index_mapped

    // the same decode guards both the write and the read address
    function automatic logic addr_hit(input logic [addr_width-1:0] a);
        addr_hit = addr_ok(a) && index_mapped(addr_index(a));
    endfunction : addr_hit

    function automatic logic [1:0] resp_code(input logic hit);
        resp_code = hit ? strap_regs_pkg::resp_okay : strap_regs_pkg::resp_slverr;
    endfunction : resp_code

    // keep only the bits that exist for the chosen package
    function automatic logic [15:0] first_mask();
        logic [15:0] m;
        m = 16'h0000;
        m[strap_regs_pkg::mirror_bit] = 1'b1;
        m[strap_regs_pkg::downshift_bit] = 1'b1;
        m[strap_regs_pkg::clk_out_off_bit] = wide_package;
        m[strap_regs_pkg::rgmii_off_bit] = 1'b1;
        m[strap_regs_pkg::crossover_off_bit] = 1'b1;
        m[strap_regs_pkg::forced_cross_bit] = 1'b1;
        m[strap_regs_pkg::half_duplex_bit] = 1'b1;
        m[strap_regs_pkg::autoneg_off_bit] = 1'b1;
        // speed and address fields lose their top bit on the smaller package
        m[strap_regs_pkg::speed_lsb] = 1'b1;
        m[strap_regs_pkg::speed_lsb + 1] = wide_package;
        m[strap_regs_pkg::address_lsb +: 4] = 4'hf;
        m[strap_regs_pkg::address_lsb + 4] = wide_package;
        first_mask = m;
    endfunction : first_mask

    function automatic logic [15:0] second_mask();
        logic [15:0] m;
        m = 16'h0000;
        m[strap_regs_pkg::quick_drop_bit] = 1'b1;
        m[strap_regs_pkg::tx_delay_lsb +: 3] = {3{~wide_package}};
        m[strap_regs_pkg::rx_delay_lsb +: 3] = {3{~wide_package}};
        second_mask = m;
    endfunction : second_mask

    // next run length; stops at the field maximum rather than wrapping
    function automatic logic [3:0] run_step(input logic [3:0] run);
        run_step = (run == 4'hf) ? run : run + 4'h1;
    endfunction : run_step

    // compared one bit wider so a full run of 15 cannot wrap to zero
    function automatic logic run_reaches_limit(input logic [3:0] run, input logic [3:0] limit);
        run_reaches_limit = ({1'b0, run} + 5'h01) >= {1'b0, limit};
    endfunction : run_reaches_limit

    // only the threshold field takes writes; every other field is read-only
    function automatic logic [3:0] written_limit(
        input logic [3:0] old,
        input logic [7:0] i,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [3:0] v;
        v = old;
        case (i)
            strap_regs_pkg::idle_cfg_index:
            begin
                if (strb[0])
                begin
                    v = data[strap_regs_pkg::idle_limit_lsb +: 4];
                end
            end
            default:
            begin
                // read-only registers and reserved bits drop the data
                v = old;
            end
        endcase
        written_limit = v;
    endfunction : written_limit

    function automatic logic [15:0] read_word(input state_t s, input logic [7:0] i);
        logic [15:0] v;
        v = 16'h0000;
        case (i)
            strap_regs_pkg::idle_cfg_index:
            begin
                v = {strap_regs_pkg::idle_cfg_reserved, s.idle_symbol_count_limit};
            end
            strap_regs_pkg::skew_index:
            begin
                v = {8'h00, s.skew};
            end
            strap_regs_pkg::strap_first_index:
            begin
                v = s.strap_first;
            end
            strap_regs_pkg::strap_second_index:
            begin
                v = s.strap_second;
            end
            default:
            begin
                v = 16'h0000;
            end
        endcase
        read_word = v;
    endfunction : read_word

    always_comb
    begin
        next_st = st;

        // pins pass two flops before the capture uses them
        next_st.first_meta = strap_first_pins;
        next_st.first_sync = st.first_meta;
        next_st.second_meta = strap_second_pins;
        next_st.second_sync = st.second_meta;
        case (st.cap)
            cap_sync0:
            begin
                next_st.cap = cap_sync1;
            end
            cap_sync1:
            begin
                // capture once; later pin changes are not seen
                next_st.strap_first = st.first_sync & first_mask();
                next_st.strap_second = st.second_sync & second_mask();
                next_st.cap = cap_done;
            end
            cap_done:
            begin
                next_st.cap = cap_done;
            end
            default:
            begin
                next_st.cap = cap_sync0;
            end
        endcase

        // skew inputs come from same-clock alignment logic
        next_st.skew[strap_regs_pkg::lane_b_lsb +: 4] = lane_b_delay_cycles;
        next_st.skew[strap_regs_pkg::lane_a_lsb +: 4] = lane_a_delay_cycles;

        // any non-idle symbol breaks the run
        case ({symbol_strobe, idle_symbol_strobe})
            2'b10:
            begin
                next_st.idle_run = 4'h0;
                next_st.idle_mode = 1'b0;
            end
            2'b11:
            begin
                next_st.idle_run = run_step(st.idle_run);
                if (run_reaches_limit(st.idle_run, st.idle_symbol_count_limit))
                begin
                    next_st.idle_mode = 1'b1;
                end
            end
            default:
            begin
                // no symbol this cycle, so run and mode hold
                next_st.idle_run = st.idle_run;
            end
        endcase

        // write path: address and data in either order, one write at a time
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.awready = 1'b0;
            next_st.aw_index = addr_index(s_axi_awaddr);
            next_st.aw_ok = addr_hit(s_axi_awaddr);
        end

        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_held = 1'b1;
            next_st.wready = 1'b0;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end

        // the response goes out the edge after both halves are held
        if (st.aw_held && st.w_held && !st.bvalid)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = resp_code(st.aw_ok);
            if (st.aw_ok)
            begin
                next_st.idle_symbol_count_limit = written_limit(st.idle_symbol_count_limit,
                    st.aw_index, st.w_data, st.w_strb);
            end
        end

        // ready stays low until the response is taken, so a second request waits
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end

        // read path: one read at a time
        if (s_axi_arvalid && st.arready)
        begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            if (addr_hit(s_axi_araddr))
            begin
                next_st.rdata = {16'h0000, read_word(st, addr_index(s_axi_araddr))};
                next_st.rresp = strap_regs_pkg::resp_okay;
            end
            else
            begin
                // an unmapped read answers zero data with an error
                next_st.rdata = 32'h0000_0000;
                next_st.rresp = strap_regs_pkg::resp_slverr;
            end
        end

        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end

        if (!aresetn)
        begin
            next_st = '0;
            next_st.cap = cap_sync0;
            next_st.idle_symbol_count_limit = strap_regs_pkg::idle_limit_reset;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
            next_st.arready = 1'b1;
            // synchronisers keep shifting so the capture after release sees the pins
            next_st.first_meta = strap_first_pins;
            next_st.first_sync = st.first_meta;
            next_st.second_meta = strap_second_pins;
            next_st.second_sync = st.second_meta;
        end
    end

    always_ff @(posedge aclk)
    begin
        st <= next_st;
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign idle_mode = st.idle_mode;
endmodule : phy_strap_and_symbol_status_regs

// ### tb/strap_regs_checker_props.sv
// Purpose: bus handshake and idle detector properties
// Assumes: single clock aclk, synchronous active-low aresetn
// Notes: sees only the top module's ports
`timescale 1ns/10ps
module strap_regs_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic idle_symbol_strobe,
    input wire logic symbol_strobe,
    input wire logic idle_mode
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data not held");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_wans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid; endproperty
    a_wans: assert property (p_wans) else $error("write answer late");
    property p_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_errzero; s_axi_rvalid && s_axi_rresp == strap_regs_pkg::resp_slverr
        |-> s_axi_rdata == 32'h0000_0000; endproperty
    a_errzero: assert property (p_errzero) else $error("error read has data");
    property p_idle_off; symbol_strobe && !idle_symbol_strobe |=> !idle_mode; endproperty
    a_idle_off: assert property (p_idle_off) else $error("idle mode after busy symbol");
    property p_idle_keep; !symbol_strobe |=> $stable(idle_mode); endproperty
    a_idle_keep: assert property (p_idle_keep) else $error("idle mode moved alone");
endmodule : strap_regs_checker
bind phy_strap_and_symbol_status_regs strap_regs_checker u_chk (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .idle_symbol_strobe, .symbol_strobe, .idle_mode);

// ### tb/tb_phy_strap_and_symbol_status_regs.sv
// Purpose: directed register and idle detector test
// Assumes: wide package, byte address = 4 * index
// Notes: straps all ones first, all zeros after a mid-run reset
`timescale 1ns/10ps
module tb_phy_strap_and_symbol_status_regs;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [15:0] strap_first_pins = 16'hffff, strap_second_pins = 16'hffff;
    logic [3:0] lane_a_delay_cycles = 4'h3, lane_b_delay_cycles = 4'ha;
    logic idle_symbol_strobe = 1'b0, symbol_strobe = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, idle_mode;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int fails = 0;
    int checks = 0;
    int ready_lag = 0;
    always #5 aclk = ~aclk;
    phy_strap_and_symbol_status_regs DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .strap_first_pins, .strap_second_pins, .lane_a_delay_cycles, .lane_b_delay_cycles,
        .idle_symbol_strobe, .symbol_strobe, .idle_mode);
    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (ready_lag == 0);
        for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (n + 1 == ready_lag) s_axi_bready <= 1'b1;
        end
        if (n == 50) fails++;
        if (n == 50) finish_test();
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (ready_lag == 0);
        for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n + 1 == ready_lag) s_axi_rready <= 1'b1;
        end
        if (n == 50) fails++;
        if (n == 50) finish_test();
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd_chk
    task automatic sym(input logic idle, input logic exp);
        symbol_strobe <= 1'b1;
        idle_symbol_strobe <= idle;
        @(posedge aclk);
        symbol_strobe <= 1'b0;
        @(posedge aclk);
        chk({31'h0, idle_mode}, {31'h0, exp});
    endtask : sym
    task automatic test_values;
        rd_chk(12'h14c, 32'h0000_2055, 2'b00);
        rd_chk(12'h154, 32'h0000_00a3, 2'b00);
        rd_chk(12'h1b8, 32'h0000_f7ff, 2'b00);
        rd_chk(12'h1bc, 32'h0000_0400, 2'b00);
        wr(12'h1b8, 32'h0000_0000, 2'b00);
        wr(12'h154, 32'h0000_0000, 2'b00);
        rd_chk(12'h1b8, 32'h0000_f7ff, 2'b00);
        rd_chk(12'h154, 32'h0000_00a3, 2'b00);
        $display("values done");
    endtask : test_values
    task automatic test_idle;
        wr(12'h14c, 32'hffff_fff4, 2'b00);
        rd_chk(12'h14c, 32'h0000_2054, 2'b00);
        for (int i = 0; i < 4; i++)
            sym(1'b1, i == 3);
        sym(1'b1, 1'b1);
        sym(1'b0, 1'b0);
        sym(1'b1, 1'b0);
        $display("idle done");
    endtask : test_idle
    task automatic test_errors;
        rd_chk(12'h000, 32'h0000_0000, strap_regs_pkg::resp_slverr);
        wr(12'h14e, 32'h0000_0001, strap_regs_pkg::resp_slverr);
        rd_chk(12'h14c, 32'h0000_2054, 2'b00);
        $display("errors done");
    endtask : test_errors
    task automatic test_slow_ready;
        ready_lag = 3;
        wr(12'h14c, 32'h0000_0005, 2'b00);
        rd_chk(12'h14c, 32'h0000_2055, 2'b00);
        ready_lag = 0;
        $display("slow ready done");
    endtask : test_slow_ready
    task automatic test_recapture;
        strap_first_pins <= 16'h0000;
        strap_second_pins <= 16'h0000;
        repeat (3) @(posedge aclk);
        rd_chk(12'h1b8, 32'h0000_f7ff, 2'b00);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rd_chk(12'h1b8, 32'h0000_0000, 2'b00);
        rd_chk(12'h1bc, 32'h0000_0000, 2'b00);
        rd_chk(12'h14c, 32'h0000_2055, 2'b00);
        $display("recapture done");
    endtask : test_recapture
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        test_values();
        test_idle();
        test_errors();
        test_slow_ready();
        test_recapture();
        finish_test();
    end
endmodule : tb_phy_strap_and_symbol_status_regs
